// ---- core/uemu_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module uemu_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_pop,
  output logic [W-1:0] o_rdata,
  output logic [CW-1:0] o_count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;

  // caller gates push on full and pop on empty
  wire [AW-1:0] wp_nx = (wp_q == LAST) ? '0 : wp_q + 1'b1;
  wire [AW-1:0] rp_nx = (rp_q == LAST) ? '0 : rp_q + 1'b1;

  always_ff @(posedge i_clk_sys) begin
    if (i_push) begin
      mem_q[wp_q] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || i_flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (i_push) begin
        wp_q <= wp_nx;
      end
      if (i_pop) begin
        rp_q <= rp_nx;
      end
      if (i_push && !i_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (i_pop && !i_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign o_rdata = mem_q[rp_q];
  assign o_count = cnt_q;
endmodule // uemu_fifo
`default_nettype wire

// ---- core/uemu_host_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module uemu_host_port import uemu_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_host_cs_n,
  input wire logic i_host_rd_n,
  input wire logic i_host_wr_n,
  input wire logic [2:0] i_host_addr,
  input wire logic [7:0] i_host_data,
  output logic [7:0] o_host_data,
  output logic o_host_data_oe_n,
  output logic o_host_intr,
  input wire logic [7:0] i_mpu_addr,
  input wire logic i_mpu_rd,
  input wire logic i_mpu_wr,
  input wire logic [7:0] i_mpu_wdata,
  output logic [7:0] o_mpu_rdata,
  output logic o_mpu_intr,
  output logic o_dma_mode1
);
  localparam int CW = $clog2(DEPTH + 1);

  // host pin synchroniser: three stages, control counts when stages 2 and 3 agree
  logic [13:0] sync1_q, sync2_q, sync3_q;
  logic [2:0] ctl_q;
  uemu_hacc_e hst_q;
  logic [2:0] cap_addr_q, rd_addr_q;
  logic [7:0] cap_data_q, hrd_q, mrd_q;
  logic [7:0] lcr_q;
  logic [3:0] ier_q, ctrl_q, shadow_q, lsr_err_q;
  logic fcr_en_q, dma_q, fifo_on_q;
  logic [1:0] trig_q;
  logic chg_q, ovr_q, txrst_sh_q, rxrst_sh_q, pend_q;
  logic thre_q, dr_ok_q;
  logic [TMR_W-1:0] rx_tmr_q, tx_tmr_q;
  logic [7:0] rx_head, tx_head;
  logic [CW-1:0] rx_cnt, tx_cnt;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sync1_q <= 14'h3800;
      sync2_q <= 14'h3800;
      sync3_q <= 14'h3800;
      ctl_q <= 3'h7;
    end else begin
      sync1_q <= {i_host_cs_n, i_host_rd_n, i_host_wr_n, i_host_addr, i_host_data};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q[13:11] == sync3_q[13:11]) begin
        ctl_q <= sync3_q[13:11];
      end
    end
  end

  wire rd_on = !ctl_q[2] && !ctl_q[1];
  wire wr_on = !ctl_q[2] && !ctl_q[0];
  wire [2:0] h_addr = sync3_q[10:8];
  wire wr_seen = !sync3_q[13] && !sync3_q[11]; // stage 3 may already show a released bus
  wire rd_start = (hst_q == HA_IDLE) && rd_on;
  wire rd_end = (hst_q == HA_READ) && !rd_on;
  wire wr_end = (hst_q == HA_WRITE) && !wr_on;
  wire div_acc = lcr_q[LCR_DIV_ACCESS];

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hst_q <= HA_IDLE;
    end else begin
      case (hst_q)
        HA_IDLE: hst_q <= rd_on ? HA_READ : (wr_on ? HA_WRITE : HA_IDLE);
        HA_READ: hst_q <= rd_on ? HA_READ : HA_IDLE;
        HA_WRITE: hst_q <= wr_on ? HA_WRITE : HA_IDLE;
        default: hst_q <= HA_IDLE;
      endcase
    end
  end

  // write data is taken while the strobe is still low, applied at its release
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cap_addr_q <= 3'h0;
      cap_data_q <= 8'h00;
      rd_addr_q <= 3'h0;
    end else begin
      if (wr_on && wr_seen) begin
        cap_addr_q <= h_addr;
        cap_data_q <= sync3_q[7:0];
      end
      if (rd_start) begin
        rd_addr_q <= h_addr;
      end
    end
  end

  // host decode
  wire hw_thr = wr_end && (cap_addr_q == HOST_DATA) && !div_acc;
  wire hw_ier = wr_end && (cap_addr_q == HOST_IER) && !div_acc;
  wire hw_fcr = wr_end && (cap_addr_q == HOST_FCR_IIR);
  wire hw_lcr = wr_end && (cap_addr_q == HOST_LCR);
  wire hr_rbr = rd_end && (rd_addr_q == HOST_DATA) && !div_acc;
  wire hr_lsr = rd_end && (rd_addr_q == HOST_LSR);
  wire fcr_ok = cap_data_q[FCR_EN];
  wire rx_rst = hw_fcr && fcr_ok && cap_data_q[FCR_RXRST];
  wire tx_rst = hw_fcr && fcr_ok && cap_data_q[FCR_TXRST];

  // local decode
  wire mr_data = i_mpu_rd && (i_mpu_addr == MPU_DATA);
  wire mw_data = i_mpu_wr && (i_mpu_addr == MPU_DATA);
  wire mr_fcr = i_mpu_rd && (i_mpu_addr == MPU_FCR);
  wire mr_pend = i_mpu_rd && (i_mpu_addr == MPU_PEND);
  wire mw_err = i_mpu_wr && (i_mpu_addr == MPU_ERR);
  wire mw_ctrl = i_mpu_wr && (i_mpu_addr == MPU_CTRL);

  // fifo mode and flushes
  wire fifo_on = fcr_en_q && !ctrl_q[CTRL_FORCE_OFF];
  wire fifo_chg = fifo_on != fifo_on_q;
  wire flush_rx = rx_rst || fifo_chg;
  wire flush_tx = tx_rst || fifo_chg;
  // outside fifo mode the same storage behaves as a one-byte holding register
  wire [CW-1:0] limit = fifo_on ? CW'(DEPTH) : CW'(1);
  wire rx_full = rx_cnt >= limit;
  wire tx_full = tx_cnt >= limit;
  wire rx_empty = rx_cnt == '0;
  wire tx_empty = tx_cnt == '0;
  // overrun push on the receive side is dropped, the stored bytes stay intact
  wire rx_push = mw_data && !rx_full && !flush_rx;
  wire rx_pop = hr_rbr && !rx_empty && !flush_rx;
  wire tx_push = hw_thr && !tx_full && !flush_tx;
  wire tx_pop = mr_data && !tx_empty && !flush_tx;
  wire tx_ovr = hw_thr && tx_full;

  uemu_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_flush(flush_rx),
    .i_push(rx_push),
    .i_wdata(i_mpu_wdata),
    .i_pop(rx_pop),
    .o_rdata(rx_head),
    .o_count(rx_cnt)
  );

  uemu_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_flush(flush_tx),
    .i_push(tx_push),
    .i_wdata(cap_data_q),
    .i_pop(tx_pop),
    .o_rdata(tx_head),
    .o_count(tx_cnt)
  );

  // timers and data-ready / empty gating
  wire rx_tmr_done = rx_tmr_q == TMR_W'(1);
  wire tx_tmr_done = tx_tmr_q == TMR_W'(1);
  wire tx_last = tx_pop && (tx_cnt == CW'(1));
  wire thre_set = (tx_last && !ctrl_q[CTRL_TX_TMR]) || tx_tmr_done;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || fifo_chg) begin
      rx_tmr_q <= '0;
      tx_tmr_q <= '0;
      dr_ok_q <= 1'b0;
      thre_q <= 1'b1;
    end else begin
      if (rx_push && ctrl_q[CTRL_RX_TMR]) begin
        rx_tmr_q <= RX_TIMER_CYC;
        dr_ok_q <= 1'b0;
      end else if (rx_push || rx_tmr_done) begin
        rx_tmr_q <= '0;
        dr_ok_q <= 1'b1;
      end else if (rx_tmr_q != '0) begin
        rx_tmr_q <= rx_tmr_q - 1'b1;
      end
      if (tx_last && ctrl_q[CTRL_TX_TMR]) begin
        tx_tmr_q <= TX_TIMER_CYC;
      end else if (tx_tmr_q != '0) begin
        tx_tmr_q <= tx_tmr_q - 1'b1;
      end
      if (tx_push) begin
        thre_q <= 1'b0;
      end else if (thre_set || flush_tx) begin
        thre_q <= 1'b1;
      end
    end
  end

  // fifo control and sticky flags; a set in the clearing cycle wins
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      fcr_en_q <= 1'b0;
      fifo_on_q <= 1'b0;
      dma_q <= 1'b0;
      trig_q <= TRIG_RST;
      chg_q <= 1'b0;
      ovr_q <= 1'b0;
      txrst_sh_q <= 1'b0;
      rxrst_sh_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      fifo_on_q <= fifo_on;
      if (hw_fcr) begin
        fcr_en_q <= cap_data_q[FCR_EN];
      end
      if (hw_fcr && fcr_ok) begin
        dma_q <= cap_data_q[FCR_DMA];
        trig_q <= cap_data_q[FCR_TRIG+:2];
      end
      chg_q <= hw_fcr || (chg_q && !mr_fcr);
      ovr_q <= tx_ovr || (ovr_q && !mr_fcr);
      txrst_sh_q <= tx_rst || (txrst_sh_q && !mr_fcr);
      rxrst_sh_q <= rx_rst || (rxrst_sh_q && !mr_fcr);
      pend_q <= hw_thr || (pend_q && !mr_pend && !fifo_chg);
    end
  end

  // host registers and line error bits
  logic [3:0] shown_err;
  assign shown_err = hr_lsr ? hrd_q[4:1] : 4'h0;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      lcr_q <= LCR_RST;
      ier_q <= IER_RST;
      ctrl_q <= CTRL_RST;
      shadow_q <= 4'h0;
      lsr_err_q <= 4'h0;
    end else begin
      if (hw_lcr) begin
        lcr_q <= cap_data_q;
      end
      if (hw_ier) begin
        ier_q <= cap_data_q[3:0];
      end
      if (mw_ctrl) begin
        ctrl_q <= i_mpu_wdata[3:0];
      end
      if (mw_err) begin
        shadow_q <= i_mpu_wdata[4:1];
      end
      // only bits the host actually saw are cleared by its read
      if (fifo_chg) begin
        lsr_err_q <= 4'h0;
      end else if (rx_push) begin
        lsr_err_q <= (lsr_err_q & ~shown_err) | shadow_q;
      end else begin
        lsr_err_q <= lsr_err_q & ~shown_err;
      end
    end
  end

  // interrupt status
  wire [7:0] trig_lvl8 = trig_q[1] ? (trig_q[0] ? TRIG_14 : TRIG_8)
    : (trig_q[0] ? TRIG_4 : TRIG_1);
  wire [CW-1:0] trig_lvl = fifo_on ? CW'(trig_lvl8) : CW'(1);
  wire data_ready = !rx_empty && dr_ok_q;
  wire int_err = ier_q[IER_ERR] && (lsr_err_q != 4'h0);
  wire int_rda = ier_q[IER_RDA] && data_ready && (rx_cnt >= trig_lvl);
  wire int_thre = ier_q[IER_THRE] && thre_q;
  wire [2:0] iid = int_err ? IID_ERR : int_rda ? IID_RDA : int_thre ? IID_THRE : IID_NONE;
  wire int_any = int_err || int_rda || int_thre;
  wire [7:0] iir_val = {{2{fifo_on}}, 2'h0, iid, !int_any};
  wire [7:0] lsr_val = {1'b0, thre_q && tx_empty, thre_q, lsr_err_q, data_ready};
  wire [7:0] fcr_val = {trig_q, chg_q, ovr_q, dma_q, txrst_sh_q, rxrst_sh_q, fcr_en_q};

  logic [7:0] hsel;
  always_comb begin
    case (h_addr)
      HOST_DATA: hsel = div_acc ? 8'h00 : rx_head;
      HOST_IER: hsel = div_acc ? 8'h00 : {4'h0, ier_q};
      HOST_FCR_IIR: hsel = iir_val;
      HOST_LCR: hsel = lcr_q;
      HOST_LSR: hsel = lsr_val;
      default: hsel = 8'h00;
    endcase
  end

  logic [7:0] msel;
  always_comb begin
    case (i_mpu_addr)
      MPU_DATA: msel = tx_head;
      MPU_FCR: msel = fcr_val;
      MPU_ERR: msel = {3'h0, shadow_q, 1'b0};
      MPU_PEND: msel = {7'h00, pend_q};
      MPU_CTRL: msel = {4'h0, ctrl_q};
      default: msel = 8'h00;
    endcase
  end

  // host read value frozen for the whole strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hrd_q <= 8'h00;
      mrd_q <= 8'h00;
    end else begin
      if (rd_start) begin
        hrd_q <= hsel;
      end
      if (i_mpu_rd) begin
        mrd_q <= msel;
      end
    end
  end

  assign o_host_data = hrd_q;
  assign o_host_data_oe_n = hst_q != HA_READ;
  assign o_host_intr = int_any;
  assign o_mpu_rdata = mrd_q;
  assign o_mpu_intr = ctrl_q[CTRL_INT_EN] && (pend_q || chg_q || ovr_q);
  assign o_dma_mode1 = dma_q && fifo_on;
endmodule // uemu_host_port
`default_nettype wire

// ---- core/uemu_pkg.sv ----
package uemu_pkg;
  // clock and timing
  localparam int CLK_MHZ = 40;
  localparam int RX_TIMER_NS = 1000;
  localparam int TX_TIMER_NS = 1000;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] RX_TIMER_CYC = TMR_W'((RX_TIMER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] TX_TIMER_CYC = TMR_W'((TX_TIMER_NS * CLK_MHZ + 999) / 1000);
  localparam int FIFO_DEPTH = 16;

  // host side offsets
  localparam logic [2:0] HOST_DATA = 3'h0;
  localparam logic [2:0] HOST_IER = 3'h1;
  localparam logic [2:0] HOST_FCR_IIR = 3'h2;
  localparam logic [2:0] HOST_LCR = 3'h3;
  localparam logic [2:0] HOST_LSR = 3'h5;

  // local processor side offsets (low address byte)
  localparam logic [7:0] MPU_DATA = 8'hf0;
  localparam logic [7:0] MPU_FCR = 8'he9;
  localparam logic [7:0] MPU_ERR = 8'hf5;
  localparam logic [7:0] MPU_PEND = 8'hf8;
  localparam logic [7:0] MPU_CTRL = 8'hfa;

  // fifo control fields and the line control divisor access bit
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMA = 3;
  localparam int FCR_OVR = 4;
  localparam int FCR_CHG = 5;
  localparam int FCR_TRIG = 6;
  localparam int LCR_DIV_ACCESS = 7;

  // local control fields
  localparam int CTRL_FORCE_OFF = 0;
  localparam int CTRL_RX_TMR = 1;
  localparam int CTRL_TX_TMR = 2;
  localparam int CTRL_INT_EN = 3;

  // host interrupt enable fields
  localparam int IER_RDA = 0;
  localparam int IER_THRE = 1;
  localparam int IER_ERR = 2;

  // receive trigger levels
  localparam logic [7:0] TRIG_1 = 8'h01;
  localparam logic [7:0] TRIG_4 = 8'h04;
  localparam logic [7:0] TRIG_8 = 8'h08;
  localparam logic [7:0] TRIG_14 = 8'h0e;

  // interrupt id codes
  localparam logic [2:0] IID_ERR = 3'h3;
  localparam logic [2:0] IID_RDA = 3'h2;
  localparam logic [2:0] IID_THRE = 3'h1;
  localparam logic [2:0] IID_NONE = 3'h0;

  // reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [3:0] IER_RST = 4'h0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] TRIG_RST = 2'h0;

  typedef enum logic [1:0] {HA_IDLE, HA_READ, HA_WRITE} uemu_hacc_e;
endpackage

// ---- testbench/uemu_host_bfm.sv ----
`timescale 1ns/100ps
`default_nettype none
module uemu_host_bfm (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  input wire logic i_oe_n,
  output var logic o_cs_n,
  output var logic o_rd_n,
  output var logic o_wr_n,
  output var logic [2:0] o_addr,
  output var logic [7:0] o_data
);
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 3'h0;
    o_data = 8'h00;
  end
  // write strobe held six cycles, read strobe until output enable plus four more; both well over the four the sync needs
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    q = 'x;
    @(posedge i_clk_sys);
    #1;
    o_addr = a;
    o_cs_n = 1'b0;
    if (wr) begin
      o_data = d;
      o_wr_n = 1'b0;
      repeat (6) @(posedge i_clk_sys);
      #1;
      o_wr_n = 1'b1;
    end else begin
      o_rd_n = 1'b0;
      for (n = 0; n < 20 && i_oe_n !== 1'b0; n++) begin
        @(posedge i_clk_sys);
        #1;
      end
      q = i_rdata;
      repeat (4) @(posedge i_clk_sys);
      #1;
      o_rd_n = 1'b1;
    end
    o_cs_n = 1'b1;
    // released lines flip so a stale value cannot pass
    o_addr = ~o_addr;
    o_data = ~o_data;
    repeat (6) @(posedge i_clk_sys);
  endtask
endmodule // uemu_host_bfm
`default_nettype wire

// ---- testbench/uemu_host_port_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module uemu_host_port_props import uemu_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_host_cs_n,
  input wire logic i_host_rd_n,
  input wire logic i_host_wr_n,
  input wire logic [2:0] i_host_addr,
  input wire logic [7:0] i_host_data,
  input wire logic [7:0] o_host_data,
  input wire logic o_host_data_oe_n,
  input wire logic o_host_intr,
  input wire logic [7:0] i_mpu_addr,
  input wire logic i_mpu_rd,
  input wire logic i_mpu_wr,
  input wire logic [7:0] i_mpu_wdata,
  input wire logic [7:0] o_mpu_rdata,
  input wire logic o_mpu_intr,
  input wire logic o_dma_mode1
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_rd(a);
    i_mpu_rd && i_mpu_addr == a;
  endsequence
  // second read sees flags already cleared by the first; a host write
  // ending at the first read would set them again, so wr_n must be high 5 back
  sequence s_rd2(a);
    (i_mpu_rd && i_mpu_addr == a && $past(i_host_wr_n, 5)) ##1 s_rd(a);
  endsequence

  a_rst_quiet: assert property (disable iff (1'b0) i_sys_rst |=>
    !o_host_intr && !o_mpu_intr && !o_dma_mode1 && o_host_data_oe_n && o_mpu_rdata == 8'h00)
    else $error("outputs active after reset");
  // three sync flops hide a fresh read strobe
  a_oe_delay: assert property ($fell(i_host_rd_n) && !i_host_cs_n |->
    o_host_data_oe_n [*3])
    else $error("host data driven too early");
  a_oe_cause: assert property ($fell(o_host_data_oe_n) |->
    !i_host_rd_n && !i_host_cs_n && !$past(i_host_rd_n, 3))
    else $error("host data driven without read");
  a_data_hold: assert property (!o_host_data_oe_n && !$past(o_host_data_oe_n) |->
    $stable(o_host_data))
    else $error("host read data changed mid read");
  a_oe_release: assert property ($rose(i_host_rd_n) |-> ##[1:8] o_host_data_oe_n)
    else $error("host data not released");
  a_int_gate: assert property (i_mpu_wr && i_mpu_addr == MPU_CTRL &&
    !i_mpu_wdata[CTRL_INT_EN] |=> !o_mpu_intr)
    else $error("local interrupt while disabled");
  a_pend_clr: assert property (s_rd2(MPU_PEND) |=> o_mpu_rdata == 8'h00)
    else $error("pending flags not cleared by read");
  a_fcr_clr: assert property (s_rd2(MPU_FCR) |=>
    o_mpu_rdata[5:4] == 2'h0 && o_mpu_rdata[2:1] == 2'h0)
    else $error("fifo control flags not cleared by read");
endmodule // uemu_host_port_props

bind uemu_host_port uemu_host_port_props u_props (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_host_cs_n(i_host_cs_n),
  .i_host_rd_n(i_host_rd_n), .i_host_wr_n(i_host_wr_n), .i_host_addr(i_host_addr),
  .i_host_data(i_host_data), .o_host_data(o_host_data),
  .o_host_data_oe_n(o_host_data_oe_n), .o_host_intr(o_host_intr),
  .i_mpu_addr(i_mpu_addr), .i_mpu_rd(i_mpu_rd), .i_mpu_wr(i_mpu_wr),
  .i_mpu_wdata(i_mpu_wdata), .o_mpu_rdata(o_mpu_rdata), .o_mpu_intr(o_mpu_intr),
  .o_dma_mode1(o_dma_mode1));
`default_nettype wire

// ---- testbench/uemu_host_port_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module uemu_host_port_tb import uemu_pkg::*;;
  logic clk = 1'b0;
  logic rst, cs_n, rd_n, wr_n, oe_n, h_intr, m_intr, dma, m_rd, m_wr;
  logic [2:0] h_addr;
  logic [7:0] h_wd, h_rd, m_addr, m_wd, m_rdata, q, f;
  logic [7:0] lvl [4];
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  uemu_host_port u_uemu_host_port (.i_clk_sys(clk), .i_sys_rst(rst), .i_host_cs_n(cs_n),
    .i_host_rd_n(rd_n), .i_host_wr_n(wr_n), .i_host_addr(h_addr), .i_host_data(h_wd),
    .o_host_data(h_rd), .o_host_data_oe_n(oe_n), .o_host_intr(h_intr),
    .i_mpu_addr(m_addr), .i_mpu_rd(m_rd), .i_mpu_wr(m_wr), .i_mpu_wdata(m_wd),
    .o_mpu_rdata(m_rdata), .o_mpu_intr(m_intr), .o_dma_mode1(dma));
  uemu_host_bfm u_uemu_host_bfm (.i_clk_sys(clk), .i_rdata(h_rd), .i_oe_n(oe_n),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(h_addr), .o_data(h_wd));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    u_uemu_host_bfm.access(1'b1, a, d, q);
  endtask
  task automatic hr(input logic [2:0] a);
    u_uemu_host_bfm.access(1'b0, a, 8'h00, q);
  endtask
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    m_addr = a;
    m_wd = d;
    m_wr = 1'b1;
    @(posedge clk);
    #1;
    m_wr = 1'b0;
  endtask
  // n back-to-back reads; f keeps the first answer, q the last
  task automatic mr(input logic [7:0] a, input int n);
    @(posedge clk);
    #1;
    m_addr = a;
    m_rd = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      if (i == 0) f = m_rdata;
    end
    m_rd = 1'b0;
    q = m_rdata;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    m_rd = 1'b0;
    m_wr = 1'b0;
    m_addr = 8'h00;
    m_wd = 8'h00;
    lvl = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({5'h0, h_intr, m_intr, dma}, 8'h00);
    hr(HOST_LSR);
    chk(q & 8'h21, 8'h20);
    hw(HOST_DATA, 8'ha5);
    hr(HOST_LSR);
    chk(q & 8'h20, 8'h00);
    mr(MPU_PEND, 2);
    chk(f, 8'h01);
    chk(q, 8'h00);
    mr(MPU_DATA, 1);
    chk(q, 8'ha5);
    hr(HOST_LSR);
    chk(q & 8'h20, 8'h20);
    hw(HOST_LCR, 8'h80);
    hw(HOST_DATA, 8'h44);
    hw(HOST_LCR, 8'h00);
    mr(MPU_PEND, 1);
    chk(q, 8'h00);
    mw(MPU_CTRL, 8'h08);
    hw(HOST_DATA, 8'h5a);
    chk(8'(m_intr), 8'h01);
    mr(MPU_PEND, 1);
    mr(MPU_DATA, 1);
    chk(8'(m_intr), 8'h00);
    mw(MPU_CTRL, 8'h06);
    hw(HOST_DATA, 8'h77);
    mr(MPU_DATA, 1);
    hr(HOST_LSR);
    chk(q & 8'h20, 8'h00);
    hw(HOST_IER, 8'h01);
    mw(MPU_ERR, 8'h1e);
    mw(MPU_DATA, 8'h3c);
    chk(8'(h_intr), 8'h00);
    repeat (44) @(posedge clk);
    #1;
    chk(8'(h_intr), 8'h01);
    hr(HOST_FCR_IIR);
    chk(q, 8'h04);
    hr(HOST_LSR);
    chk(q & 8'h3f, 8'h3f);
    hr(HOST_DATA);
    chk(q, 8'h3c);
    chk(8'(h_intr), 8'h00);
    mw(MPU_CTRL, 8'h00);
    hw(HOST_FCR_IIR, 8'hc1);
    mr(MPU_FCR, 2);
    chk(f, 8'he1);
    chk(q, 8'hc1);
    hr(HOST_FCR_IIR);
    chk(q & 8'hc0, 8'hc0);
    for (int k = 0; k < 4; k++) begin
      hw(HOST_FCR_IIR, {k[1:0], 6'h03});
      chk(8'(h_intr), 8'h00);
      for (int j = 0; j < 14; j++) begin
        mw(MPU_DATA, 8'(j));
        if (j == lvl[k] - 2) chk(8'(h_intr), 8'h00);
        if (j == lvl[k] - 1) chk(8'(h_intr), 8'h01);
      end
    end
    mr(MPU_FCR, 1);
    chk(q & 8'h02, 8'h02);
    hr(HOST_DATA);
    chk(q, 8'h00);
    hr(HOST_DATA);
    chk(q, 8'h01);
    hw(HOST_DATA, 8'h11);
    hw(HOST_DATA, 8'h22);
    mr(MPU_DATA, 1);
    chk(q, 8'h11);
    mr(MPU_DATA, 1);
    chk(q, 8'h22);
    hw(HOST_DATA, 8'h33);
    hw(HOST_FCR_IIR, 8'h05);
    mr(MPU_FCR, 1);
    chk(q & 8'h04, 8'h04);
    hr(HOST_LSR);
    chk(q & 8'h21, 8'h21);
    hw(HOST_FCR_IIR, 8'h09);
    chk(8'(dma), 8'h01);
    hw(HOST_FCR_IIR, 8'hc8);
    chk(8'(dma), 8'h00);
    mr(MPU_FCR, 1);
    chk(q & 8'hc9, 8'h08);
    hr(HOST_LSR);
    chk(q & 8'h01, 8'h00);
    hr(HOST_FCR_IIR);
    chk(q & 8'hc0, 8'h00);
    hw(HOST_FCR_IIR, 8'h09);
    mw(MPU_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk(8'(dma), 8'h00);
    hw(HOST_DATA, 8'h01);
    hw(HOST_DATA, 8'h02);
    mr(MPU_FCR, 2);
    chk(f & 8'h10, 8'h10);
    chk(q & 8'h10, 8'h00);
    mr(MPU_DATA, 1);
    chk(q, 8'h01);
    stop_test();
  end
endmodule // uemu_host_port_tb
`default_nettype wire
